// >>> shared/omc_pkg.sv
package omc_pkg;
  // Clock
  localparam int CLK_PERIOD_NS = 4;

  // Operating modes
  typedef enum logic [2:0] {
    OMC_OFF = 3'b000,
    OMC_RESET = 3'b001,
    OMC_OVERTEMP = 3'b010,
    OMC_FORCED_NORMAL = 3'b011,
    OMC_STANDBY = 3'b100,
    OMC_NORMAL = 3'b101
  } omc_mode_e;

  // Register addresses
  localparam logic [6:0] ADDR_MODE_CONTROL = 7'h01;
  localparam logic [6:0] ADDR_MAIN_STATUS = 7'h03;
  localparam logic [6:0] ADDR_EVENT_STATUS = 7'h04;
  localparam logic [6:0] ADDR_WDOG_STATUS = 7'h05;
  localparam logic [6:0] ADDR_CAN_CONTROL = 7'h20;
  localparam logic [6:0] ADDR_IDENT = 7'h7e;
  localparam logic [6:0] ADDR_NV_BOOT_CONFIG = 7'h74;
  localparam logic [6:0] ADDR_NV_BASE = 7'h70;

  // Mode control field
  localparam logic [2:0] MODE_CODE_STANDBY = 3'h4;
  localparam logic [2:0] MODE_CODE_NORMAL = 3'h7;
  localparam int MODE_FIELD_LSB = 0;

  // Main status fields
  localparam int MS_WARN_STATE_BIT = 6;
  localparam int MS_NOT_NORMAL_BIT = 5;

  // Event status fields (flags write 1 to clear; bit 7 is the enable)
  localparam int EV_WARN_EVENT_BIT = 0;
  localparam int EV_WAKE_PENDING_BIT = 1;
  localparam int EV_WARN_EVENT_EN_BIT = 7;

  // Nonvolatile boot config
  localparam int NV_FORCED_NORMAL_BIT = 0;
  localparam logic [7:0] NV_BOOT_RESET = 8'h01;

  // CAN mode field
  localparam logic [1:0] CAN_MODE_OFFLINE = 2'h0;
  localparam logic [1:0] CAN_MODE_LISTEN = 2'h3;

  // Reset cause codes
  localparam logic [4:0] CAUSE_POWER_ON = 5'h00;
  localparam logic [4:0] CAUSE_WDOG_EARLY = 5'h0e;
  localparam logic [4:0] CAUSE_WDOG_OVERFLOW = 5'h0f;
  localparam logic [4:0] CAUSE_WDOG_ILLEGAL = 5'h10;
  localparam logic [4:0] CAUSE_EXTERNAL = 5'h11;
  localparam logic [4:0] CAUSE_OVERTEMP_EXIT = 5'h12;
  localparam logic [4:0] CAUSE_UNDERVOLT = 5'h13;

  // Identification value, arbitrary
  localparam logic [7:0] IDENT_VALUE = 8'h5a;
endpackage

// >>> rtl/omc_sync.sv
`timescale 1ns/1ns
`default_nettype none
module omc_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset_line_n,
  // Data
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] stage1;

  always_ff @(posedge clock) begin
    if (!reset_line_n) begin
      stage1 <= '0;
      sync_out <= '0;
    end else begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end
endmodule
`default_nettype wire

// >>> rtl/omc_mode_ctrl.sv
// Notes on behaviour
// - Reset mode holds reset line low for set time; SPI, watchdog, CAN receive off.
// - Any reset event from any mode but Off and Overtemp enters Reset mode.
// - Reset mode exits to Standby when reset line reads high, unless forced-normal.
// - With forced-normal config 1, Reset mode exits to Forced Normal.
// - Reset entered by regulator undervoltage stays until regulator recovers.
// - SPI accesses within the post-reset wait are silently ignored.
// - Off mode keeps only power-on detection running; battery-off enters Off.
// - Power-on detection starts init, then Off moves to Reset after start-up time.
// - Overtemperature activation enters Overtemp at once from any mode but Off.
// - Warning sets warning state; event flag captured when enable is 1.
// - Overtemp detects no wake-ups; pending wake keeps receive output low.
// - Overtemp switches regulator and CAN off, reset low after delay.
// - Overtemp exits to Reset on release, to Off on battery-off.
// - Forced Normal disables watchdog, keeps regulator and CAN active.
// - Forced-normal bit defaults 1, lives at 74h; 0 stops Forced Normal boot.
// - Reset from Forced Normal keeps transmitter on unless undervoltage.
// - Reset entered from Forced Normal returns to Forced Normal.
// - Forced Normal reads only main and watchdog status, ident, NV; NV writes while factory state.
// - Mode field at 01h: 100 is Standby, 111 is Normal.
// - Normal CAN mode from field; receive carries bus for codes 01/10/11.
// - Watchdog window behaviour allowed only in Normal mode.
// - Main status shows warning state, Normal-entered flag, last reset cause.
// - Code 111 moves Standby to Normal; code 100 moves Normal to Standby.
// - Reset cause codes as defined for each reset source.
// - A pending wake-up event forces receive output low while CAN receive is off, except in Off mode.
`timescale 1ns/1ns
`default_nettype none
module omc_mode_ctrl #(
  parameter int T_STARTUP_NS = 20000,
  parameter int T_RESET_HOLD_NS = 20000,
  parameter int T_SPI_WAIT_NS = 20000,
  parameter int T_UVD_DELAY_NS = 20000
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset_line_n,
  // Analog detectors, asynchronous
  input wire logic power_on_det,
  input wire logic power_off_det,
  input wire logic overtemp_act,
  input wire logic overtemp_rel,
  input wire logic overtemp_warn,
  input wire logic reg_undervolt,
  input wire logic wake_event,
  input wire logic can_rx_bus,
  // Reset line pin
  input wire logic reset_line_n_in,
  output logic reset_line_n_out,
  output logic reset_line_n_oe,
  // Watchdog reset events, same clock
  input wire logic wdog_early_trig,
  input wire logic wdog_overflow,
  input wire logic wdog_illegal_access,
  // Register access
  input wire logic reg_sel,
  input wire logic reg_write,
  input wire logic [6:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic reg_ack,
  output logic [7:0] reg_rdata,
  // Function control
  output omc_pkg::omc_mode_e op_mode,
  output logic regulator_en,
  output logic spi_en,
  output logic wdog_en,
  output logic wdog_window_allow,
  output logic can_tx_en,
  output logic can_rx_en,
  output logic overtemp_det_en,
  output logic rxd
);
  import omc_pkg::*;

  localparam int STARTUP_CYC = (T_STARTUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HOLD_CYC = (T_RESET_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SPI_WAIT_CYC = (T_SPI_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int UVD_CYC = (T_UVD_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [23:0] STARTUP_LAST = 24'(STARTUP_CYC - 1);
  localparam logic [23:0] HOLD_LAST = 24'(HOLD_CYC - 1);
  localparam logic [23:0] SPI_WAIT_LAST = 24'(SPI_WAIT_CYC - 1);
  localparam logic [23:0] UVD_LAST = 24'(UVD_CYC - 1);

  logic [8:0] pins_sync;
  logic s_pon, s_poff, s_ot_act, s_ot_rel, s_warn, s_uv, s_wake, s_rx, s_rst_in;
  logic [23:0] timer;
  logic timer_done;
  logic [23:0] spi_wait;
  logic spi_quiet;
  logic entered_by_uv;
  logic from_forced;
  logic [4:0] reset_cause;
  logic not_yet_normal;
  logic warn_prev;
  logic overtemp_warn_event;
  logic overtemp_warn_event_en;
  logic wake_pending;
  logic [7:0] nonvolatile_boot_config;
  logic nv_factory;
  logic [1:0] can_mode_sel;
  logic forced_normal_cfg;
  logic reset_event;
  logic [4:0] event_cause;
  logic ext_pulldown;
  logic access_ok;
  logic acc_wr;
  logic read_allowed;
  logic [7:0] next_rdata;
  logic mode_wr;
  omc_mode_e next_mode;

  // Pin levels cross into the clock domain before any use
  omc_sync #(.W(9)) u_sync (
    .clock(clock),
    .reset_line_n(reset_line_n),
    .async_in({power_on_det, power_off_det, overtemp_act, overtemp_rel, overtemp_warn,
               reg_undervolt, wake_event, can_rx_bus, reset_line_n_in}),
    .sync_out(pins_sync)
  );
  assign {s_pon, s_poff, s_ot_act, s_ot_rel, s_warn, s_uv, s_wake, s_rx, s_rst_in} = pins_sync;

  assign forced_normal_cfg = nonvolatile_boot_config[NV_FORCED_NORMAL_BIT];

  // Pull-down seen on the pin while this end is not driving it
  assign ext_pulldown = !s_rst_in && !reset_line_n_oe;

  // Reset events and their cause, undervoltage first
  always_comb begin
    reset_event = 1'b0;
    event_cause = CAUSE_EXTERNAL;
    if (op_mode != OMC_OFF && op_mode != OMC_OVERTEMP) begin
      if (s_uv) begin
        reset_event = 1'b1;
        event_cause = CAUSE_UNDERVOLT;
      end else if (op_mode != OMC_RESET) begin
        if (ext_pulldown) begin
          reset_event = 1'b1;
          event_cause = CAUSE_EXTERNAL;
        end else if (op_mode == OMC_STANDBY || op_mode == OMC_NORMAL) begin
          reset_event = wdog_early_trig | wdog_overflow | wdog_illegal_access;
          if (wdog_illegal_access) begin
            event_cause = CAUSE_WDOG_ILLEGAL;
          end else if (wdog_overflow) begin
            event_cause = CAUSE_WDOG_OVERFLOW;
          end else begin
            event_cause = CAUSE_WDOG_EARLY;
          end
        end
      end
    end
  end

  assign access_ok = reg_sel && spi_en && spi_quiet;
  assign acc_wr = access_ok && reg_write;
  assign mode_wr = acc_wr && reg_addr == ADDR_MODE_CONTROL && op_mode != OMC_FORCED_NORMAL;

  // Mode transitions
  always_comb begin
    next_mode = op_mode;
    if (s_poff) begin
      next_mode = OMC_OFF;
    end else begin
      unique case (op_mode)
        OMC_OFF: begin
          if (s_pon && timer_done) begin
            next_mode = OMC_RESET;
          end
        end
        OMC_OVERTEMP: begin
          if (s_ot_rel) begin
            next_mode = OMC_RESET;
          end
        end
        default: begin
          if (s_ot_act) begin
            next_mode = OMC_OVERTEMP;
          end else if (reset_event) begin
            next_mode = OMC_RESET;
          end else if (op_mode == OMC_RESET) begin
            if (timer_done && s_rst_in && !(entered_by_uv && s_uv)) begin
              if (forced_normal_cfg || from_forced) begin
                next_mode = OMC_FORCED_NORMAL;
              end else begin
                next_mode = OMC_STANDBY;
              end
            end
          end else if (mode_wr) begin
            if (op_mode == OMC_STANDBY &&
                reg_wdata[MODE_FIELD_LSB +: 3] == MODE_CODE_NORMAL) begin
              next_mode = OMC_NORMAL;
            end else if (op_mode == OMC_NORMAL &&
                         reg_wdata[MODE_FIELD_LSB +: 3] == MODE_CODE_STANDBY) begin
              next_mode = OMC_STANDBY;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_line_n) begin
      op_mode <= OMC_OFF;
    end else begin
      op_mode <= next_mode;
    end
  end

  // Shared timer restarts on every mode change
  always_ff @(posedge clock) begin
    if (!reset_line_n) begin
      timer <= 24'h000000;
    end else if (next_mode != op_mode || (op_mode == OMC_OFF && !s_pon)) begin
      timer <= 24'h000000;
    end else if (!timer_done) begin
      timer <= timer + 24'h000001;
    end
  end

  always_comb begin
    unique case (op_mode)
      OMC_OFF: timer_done = timer >= STARTUP_LAST;
      OMC_OVERTEMP: timer_done = timer >= UVD_LAST;
      default: timer_done = timer >= HOLD_LAST;
    endcase
  end

  // Reset history: cause, undervoltage origin, forced-normal origin
  always_ff @(posedge clock) begin
    if (!reset_line_n) begin
      reset_cause <= CAUSE_POWER_ON;
      entered_by_uv <= 1'b0;
      from_forced <= 1'b0;
    end else if (op_mode == OMC_OFF && next_mode == OMC_RESET) begin
      reset_cause <= CAUSE_POWER_ON;
      entered_by_uv <= 1'b0;
      from_forced <= 1'b0;
    end else if (op_mode == OMC_OVERTEMP && next_mode == OMC_RESET) begin
      reset_cause <= CAUSE_OVERTEMP_EXIT;
      entered_by_uv <= 1'b0;
      from_forced <= 1'b0;
    end else if (next_mode == OMC_RESET && reset_event) begin
      reset_cause <= event_cause;
      entered_by_uv <= event_cause == CAUSE_UNDERVOLT;
      if (op_mode != OMC_RESET) begin
        from_forced <= op_mode == OMC_FORCED_NORMAL;
      end
    end
  end

  // Post-reset quiet time for register access
  always_ff @(posedge clock) begin
    if (!reset_line_n) begin
      spi_wait <= 24'h000000;
    end else if (op_mode == OMC_RESET && next_mode != OMC_RESET) begin
      spi_wait <= SPI_WAIT_LAST;
    end else if (spi_wait != 24'h000000) begin
      spi_wait <= spi_wait - 24'h000001;
    end
  end
  assign spi_quiet = spi_wait == 24'h000000;

  // Normal-entered flag and warning capture
  always_ff @(posedge clock) begin
    if (!reset_line_n) begin
      not_yet_normal <= 1'b1;
    end else if (op_mode == OMC_OFF) begin
      not_yet_normal <= 1'b1;
    end else if (op_mode == OMC_NORMAL) begin
      not_yet_normal <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_line_n) begin
      warn_prev <= 1'b0;
      overtemp_warn_event <= 1'b0;
    end else begin
      warn_prev <= s_warn;
      // Capture wins over a clear in the same cycle
      if (s_warn && !warn_prev && overtemp_warn_event_en && op_mode != OMC_OFF) begin
        overtemp_warn_event <= 1'b1;
      end else if (acc_wr && reg_addr == ADDR_EVENT_STATUS && reg_wdata[EV_WARN_EVENT_BIT]) begin
        overtemp_warn_event <= 1'b0;
      end
    end
  end

  // Wake-up latch; blind in Off and Overtemp, held through Overtemp, cleared in Off
  always_ff @(posedge clock) begin
    if (!reset_line_n) begin
      wake_pending <= 1'b0;
    end else if (s_wake && op_mode != OMC_OFF && op_mode != OMC_OVERTEMP) begin
      wake_pending <= 1'b1;
    end else if (acc_wr && reg_addr == ADDR_EVENT_STATUS && reg_wdata[EV_WAKE_PENDING_BIT]) begin
      wake_pending <= 1'b0;
    end else if (op_mode == OMC_OFF) begin
      wake_pending <= 1'b0;
    end
  end

  // Register writes
  always_ff @(posedge clock) begin
    if (!reset_line_n) begin
      overtemp_warn_event_en <= 1'b0;
      can_mode_sel <= CAN_MODE_OFFLINE;
      nonvolatile_boot_config <= NV_BOOT_RESET;
      nv_factory <= 1'b1;
    end else if (acc_wr) begin
      if (op_mode != OMC_FORCED_NORMAL && reg_addr == ADDR_EVENT_STATUS) begin
        overtemp_warn_event_en <= reg_wdata[EV_WARN_EVENT_EN_BIT];
      end
      if (op_mode != OMC_FORCED_NORMAL && reg_addr == ADDR_CAN_CONTROL) begin
        can_mode_sel <= reg_wdata[1:0];
      end
      if (reg_addr == ADDR_NV_BOOT_CONFIG &&
          (op_mode != OMC_FORCED_NORMAL || nv_factory)) begin
        nonvolatile_boot_config <= reg_wdata;
        nv_factory <= 1'b0;
      end
    end
  end

  // Reads, restricted in Forced Normal
  assign read_allowed = op_mode != OMC_FORCED_NORMAL || reg_addr == ADDR_MAIN_STATUS ||
                        reg_addr == ADDR_WDOG_STATUS || reg_addr == ADDR_IDENT ||
                        reg_addr >= ADDR_NV_BASE;

  always_comb begin
    next_rdata = 8'h00;
    if (read_allowed) begin
      unique case (reg_addr)
        ADDR_MODE_CONTROL:
          next_rdata = {5'h00, (op_mode == OMC_NORMAL) ? MODE_CODE_NORMAL : MODE_CODE_STANDBY};
        ADDR_MAIN_STATUS: begin
          next_rdata[MS_WARN_STATE_BIT] = s_warn;
          next_rdata[MS_NOT_NORMAL_BIT] = not_yet_normal;
          next_rdata[4:0] = reset_cause;
        end
        ADDR_EVENT_STATUS: begin
          next_rdata[EV_WARN_EVENT_BIT] = overtemp_warn_event;
          next_rdata[EV_WAKE_PENDING_BIT] = wake_pending;
          next_rdata[EV_WARN_EVENT_EN_BIT] = overtemp_warn_event_en;
        end
        ADDR_CAN_CONTROL: next_rdata = {6'h00, can_mode_sel};
        ADDR_IDENT: next_rdata = IDENT_VALUE;
        ADDR_NV_BOOT_CONFIG: next_rdata = nonvolatile_boot_config;
        default: next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_line_n) begin
      reg_ack <= 1'b0;
      reg_rdata <= 8'h00;
    end else begin
      // Early accesses get no answer at all, not an error
      reg_ack <= access_ok;
      if (access_ok && !reg_write) begin
        reg_rdata <= next_rdata;
      end
    end
  end

  // Per-mode gating
  assign reset_line_n_out = 1'b0;
  assign reset_line_n_oe = op_mode == OMC_OFF ||
                           (op_mode == OMC_RESET && !timer_done) ||
                           (op_mode == OMC_RESET && entered_by_uv && s_uv) ||
                           (op_mode == OMC_OVERTEMP && timer_done);
  assign regulator_en = op_mode != OMC_OFF && op_mode != OMC_OVERTEMP;
  assign overtemp_det_en = op_mode != OMC_OFF;
  assign spi_en = op_mode == OMC_FORCED_NORMAL || op_mode == OMC_STANDBY ||
                  op_mode == OMC_NORMAL;
  assign wdog_en = op_mode == OMC_STANDBY || op_mode == OMC_NORMAL;
  assign wdog_window_allow = op_mode == OMC_NORMAL;
  assign can_rx_en = op_mode == OMC_FORCED_NORMAL ||
                     (op_mode == OMC_NORMAL && can_mode_sel != CAN_MODE_OFFLINE);
  assign can_tx_en = op_mode == OMC_FORCED_NORMAL ||
                     (op_mode == OMC_RESET && from_forced && !s_uv) ||
                     (op_mode == OMC_NORMAL && can_mode_sel != CAN_MODE_OFFLINE &&
                      can_mode_sel != CAN_MODE_LISTEN);

  // Receive output: bus stream when receiving, high in Off, else low while a wake is pending
  always_comb begin
    if (can_rx_en) begin
      rxd = s_rx;
    end else if (op_mode == OMC_OFF) begin
      rxd = 1'b1;
    end else begin
      rxd = !wake_pending;
    end
  end
endmodule
`default_nettype wire

// >>> dv/omc_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module omc_host_model #(
  parameter int WAIT_CYC = 16
) (
  // Clock
  input wire logic clock,
  // Reset line
  input wire logic reset_line_n_out,
  input wire logic reset_line_n_oe,
  output logic reset_line_n_in,
  // Register access
  output logic reg_sel,
  output logic reg_write,
  output logic [6:0] reg_addr,
  output logic [7:0] reg_wdata,
  input wire logic reg_ack,
  input wire logic [7:0] reg_rdata
);
  logic ext_pull = 1'b0;
  logic prev_pin = 1'b1;
  int since_rise = 0;
  // Pull-up on the pin, so either party may hold it low
  assign reset_line_n_in = !(ext_pull || (reset_line_n_oe && !reset_line_n_out));
  always @(posedge clock) begin
    prev_pin <= reset_line_n_in;
    since_rise <= (reset_line_n_in && !prev_pin) ? 0 : since_rise + 1;
  end
  initial begin
    reg_sel = 1'b0;
    reg_write = 1'b0;
    reg_addr = 7'h00;
    reg_wdata = 8'h00;
  end
  // Ack is registered on the taking edge and read half a cycle later, so the strobe lasts one cycle
  task automatic access(input logic early, input logic wr, input logic [6:0] a,
      input logic [7:0] v, output logic ok, output logic [7:0] d);
    for (int i = 0; i < 200 && !early && since_rise < WAIT_CYC; i++) @(negedge clock);
    @(negedge clock);
    reg_sel = 1'b1;
    reg_write = wr;
    reg_addr = a;
    reg_wdata = v;
    @(negedge clock);
    ok = reg_ack;
    d = reg_rdata;
    reg_sel = 1'b0;
    reg_write = ~wr;
    reg_addr = ~a;
    reg_wdata = ~v;
  endtask
endmodule
`default_nettype wire

// >>> dv/omc_mode_ctrl_assertions.sv
`timescale 1ns/1ns
`default_nettype none
module omc_mode_ctrl_checker
  import omc_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic reset_line_n,
  // Detector
  input wire logic overtemp_act,
  // Register access
  input wire logic reg_sel,
  input wire logic reg_write,
  input wire logic [6:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_ack,
  // State and enables
  input wire omc_pkg::omc_mode_e op_mode,
  input wire logic reset_line_n_oe,
  input wire logic regulator_en,
  input wire logic spi_en,
  input wire logic wdog_en,
  input wire logic wdog_window_allow,
  input wire logic can_tx_en,
  input wire logic can_rx_en,
  input wire logic overtemp_det_en
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_line_n);
  wire logic active = op_mode inside {OMC_FORCED_NORMAL, OMC_STANDBY, OMC_NORMAL};
  wire logic mode_wr = reg_sel && reg_write && reg_addr == ADDR_MODE_CONTROL;
  wire logic norm_req = mode_wr && reg_wdata[2:0] == MODE_CODE_NORMAL && op_mode == OMC_STANDBY;
  wire logic bad_req = mode_wr && !(reg_wdata[2:0] inside {MODE_CODE_STANDBY, MODE_CODE_NORMAL});
  active_pins_a: assert property (active |-> !reset_line_n_oe && spi_en)
    else $error("pin or spi wrong in active mode");
  off_quiet_a: assert property (op_mode == OMC_OFF |->
    !(regulator_en || spi_en || wdog_en || can_tx_en || can_rx_en || overtemp_det_en))
    else $error("function enabled in off mode");
  reset_fns_a: assert property (op_mode == OMC_RESET |->
    regulator_en && overtemp_det_en && !spi_en && !wdog_en)
    else $error("wrong enables in reset mode");
  reset_hold_a: assert property ((op_mode == OMC_RESET && $past(op_mode) != OMC_RESET) |->
    reset_line_n_oe [*8])
    else $error("reset pin not held low");
  ot_off_a: assert property (op_mode == OMC_OVERTEMP |->
    !(regulator_en || can_tx_en || can_rx_en))
    else $error("regulator or can on in overtemp");
  fn_cfg_a: assert property (op_mode == OMC_FORCED_NORMAL |->
    regulator_en && can_tx_en && can_rx_en && !wdog_en)
    else $error("wrong enables in forced normal");
  window_a: assert property (wdog_window_allow |-> op_mode == OMC_NORMAL)
    else $error("window allowed outside normal");
  ot_enter_a: assert property (overtemp_act && op_mode != OMC_OFF |->
    ##[1:4] op_mode == OMC_OVERTEMP)
    else $error("overtemp mode not entered");
  refuse_a: assert property (reg_sel && !spi_en |=> !reg_ack)
    else $error("access acked while spi off");
  to_normal_a: assert property (reg_ack && $past(norm_req) |-> op_mode == OMC_NORMAL)
    else $error("normal not entered on code");
  bad_code_a: assert property (reg_ack && $past(bad_req) |-> op_mode == $past(op_mode))
    else $error("mode changed on bad code");
  cover property (op_mode == OMC_NORMAL);
  cover property (op_mode == OMC_OVERTEMP);
  cover property ($past(op_mode) == OMC_RESET && op_mode == OMC_FORCED_NORMAL);
endmodule
bind omc_mode_ctrl omc_mode_ctrl_checker omc_mode_ctrl_checker_i (.*);
`default_nettype wire

// >>> dv/omc_mode_ctrl_tb.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, a) begin total_checks++; if ((a) !== (e)) begin err_count++; \
  $display("BAD %s exp %0h got %0h", n, e, a); end end
module omc_mode_ctrl_tb;
  import omc_pkg::*;
  // Short counts keep the run brief: 40 ns is 10 cycles
  localparam int TNS = 40;
  logic clock = 0, reset_line_n = 0, power_on_det = 0, power_off_det = 0, overtemp_act = 0;
  logic overtemp_rel = 1, overtemp_warn = 0, reg_undervolt = 0, wake_event = 0;
  logic can_rx_bus = 1, wdog_early_trig = 0, wdog_overflow = 0, wdog_illegal_access = 0;
  wire logic reset_line_n_in, reset_line_n_out, reset_line_n_oe, reg_sel, reg_write, reg_ack;
  wire logic [6:0] reg_addr;
  wire logic [7:0] reg_wdata, reg_rdata;
  omc_mode_e op_mode;
  wire logic regulator_en, spi_en, wdog_en, wdog_window_allow, can_tx_en, can_rx_en;
  wire logic overtemp_det_en, rxd;
  int err_count = 0, total_checks = 0;
  omc_mode_ctrl #(.T_STARTUP_NS(TNS), .T_RESET_HOLD_NS(TNS), .T_SPI_WAIT_NS(TNS),
    .T_UVD_DELAY_NS(TNS)) omc_mode_ctrl_i (.*);
  omc_host_model #(.WAIT_CYC(16)) omc_host_model_i (.*);
  initial begin
    forever #2 clock = ~clock;
  end
  task automatic give_verdict();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic wait_mode(input omc_mode_e m);
    for (int i = 0; i < 200 && op_mode !== m; i++) @(negedge clock);
    `CHK("op_mode", m, op_mode)
    if (op_mode !== m) give_verdict();
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] e, input string n);
    logic ok;
    logic [7:0] d;
    omc_host_model_i.access(1'b0, 1'b0, a, 8'h00, ok, d);
    `CHK(n, {1'b1, e}, {ok, d})
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] v);
    logic ok;
    logic [7:0] d;
    omc_host_model_i.access(1'b0, 1'b1, a, v, ok, d);
    `CHK("write ack", 1'b1, ok)
  endtask
  task automatic t_boot();
    logic ok;
    logic [7:0] d;
    @(negedge clock);
    `CHK("regulator in off", 1'b0, regulator_en)
    power_on_det = 1;
    wait_mode(OMC_RESET);
    `CHK("pin low in reset", 1'b0, reset_line_n_in)
    wait_mode(OMC_FORCED_NORMAL);
    omc_host_model_i.access(1'b1, 1'b0, ADDR_MAIN_STATUS, 8'h00, ok, d);
    `CHK("early access", 1'b0, ok)
    rd(ADDR_MAIN_STATUS, 8'h20, "boot status");
    rd(ADDR_MODE_CONTROL, 8'h00, "blocked read");
    rd(ADDR_NV_BOOT_CONFIG, NV_BOOT_RESET, "nv boot");
    wr(ADDR_NV_BOOT_CONFIG, 8'h00);
    wr(ADDR_NV_BOOT_CONFIG, 8'h01);
    rd(ADDR_NV_BOOT_CONFIG, 8'h00, "nv locked");
  endtask
  task automatic t_ext_reset();
    omc_host_model_i.ext_pull = 1;
    wait_mode(OMC_RESET);
    `CHK("tx kept", 1'b1, can_tx_en)
    omc_host_model_i.ext_pull = 0;
    wait_mode(OMC_FORCED_NORMAL);
    rd(ADDR_MAIN_STATUS, {3'b001, CAUSE_EXTERNAL}, "ext cause");
  endtask
  task automatic t_power_cycle();
    power_off_det = 1;
    power_on_det = 0;
    wait_mode(OMC_OFF);
    `CHK("pin low in off", 1'b0, reset_line_n_in)
    power_off_det = 0;
    power_on_det = 1;
    wait_mode(OMC_RESET);
    wait_mode(OMC_STANDBY);
    rd(ADDR_MAIN_STATUS, 8'h20, "pon cause");
  endtask
  task automatic t_modes();
    wr(ADDR_CAN_CONTROL, 8'h01);
    wr(ADDR_MODE_CONTROL, {5'h00, MODE_CODE_NORMAL});
    `CHK("normal", OMC_NORMAL, op_mode)
    `CHK("window", 1'b1, wdog_window_allow)
    rd(ADDR_MODE_CONTROL, 8'h07, "mode readback");
    rd(ADDR_MAIN_STATUS, 8'h00, "normal seen");
    can_rx_bus = 0;
    repeat (4) @(negedge clock);
    `CHK("rxd follows bus", 1'b0, rxd)
    can_rx_bus = 1;
    `CHK("tx active", 1'b1, can_tx_en)
    wr(ADDR_CAN_CONTROL, {6'h00, CAN_MODE_LISTEN});
    `CHK("listen only", 2'b01, {can_tx_en, can_rx_en})
    for (int c = 0; c < 7; c++) begin
      if (c != 4) begin
        wr(ADDR_MODE_CONTROL, 8'(c));
        `CHK("mode kept", OMC_NORMAL, op_mode)
      end
    end
    wr(ADDR_MODE_CONTROL, {5'h00, MODE_CODE_STANDBY});
    `CHK("standby", OMC_STANDBY, op_mode)
    can_rx_bus = 0;
    repeat (4) @(negedge clock);
    `CHK("rxd idle", 1'b1, rxd)
    can_rx_bus = 1;
  endtask
  task automatic t_wdog();
    logic [4:0] cause [3];
    cause = '{CAUSE_WDOG_EARLY, CAUSE_WDOG_OVERFLOW, CAUSE_WDOG_ILLEGAL};
    for (int k = 0; k < 3; k++) begin
      {wdog_illegal_access, wdog_overflow, wdog_early_trig} = 3'(1 << k);
      @(negedge clock);
      {wdog_illegal_access, wdog_overflow, wdog_early_trig} = 3'b000;
      wait_mode(OMC_RESET);
      wait_mode(OMC_STANDBY);
      rd(ADDR_MAIN_STATUS, {3'b000, cause[k]}, "wdog cause");
    end
  endtask
  task automatic t_uv();
    logic ok;
    logic [7:0] d;
    reg_undervolt = 1;
    wait_mode(OMC_RESET);
    omc_host_model_i.access(1'b1, 1'b0, ADDR_MAIN_STATUS, 8'h00, ok, d);
    `CHK("access in reset", 1'b0, ok)
    repeat (40) @(negedge clock);
    `CHK("uv stays", OMC_RESET, op_mode)
    `CHK("uv pin", 1'b0, reset_line_n_in)
    reg_undervolt = 0;
    wait_mode(OMC_STANDBY);
    rd(ADDR_MAIN_STATUS, {3'b000, CAUSE_UNDERVOLT}, "uv cause");
  endtask
  task automatic t_overtemp();
    wr(ADDR_EVENT_STATUS, 8'h80);
    overtemp_warn = 1;
    repeat (4) @(negedge clock);
    rd(ADDR_MAIN_STATUS, {3'b010, CAUSE_UNDERVOLT}, "warn state");
    rd(ADDR_EVENT_STATUS, 8'h81, "warn event");
    wake_event = 1;
    @(negedge clock);
    wake_event = 0;
    repeat (3) @(negedge clock);
    `CHK("wake rxd", 1'b0, rxd)
    overtemp_rel = 0;
    overtemp_act = 1;
    wait_mode(OMC_OVERTEMP);
    repeat (16) @(negedge clock);
    `CHK("ot pin", 1'b0, reset_line_n_in)
    `CHK("ot rxd", 1'b0, rxd)
    overtemp_act = 0;
    overtemp_warn = 0;
    overtemp_rel = 1;
    wait_mode(OMC_RESET);
    wait_mode(OMC_STANDBY);
    `CHK("rxd kept", 1'b0, rxd)
    rd(ADDR_MAIN_STATUS, {3'b000, CAUSE_OVERTEMP_EXIT}, "ot cause");
    wr(ADDR_EVENT_STATUS, 8'h83);
    repeat (2) @(negedge clock);
    `CHK("rxd cleared", 1'b1, rxd)
  endtask
  initial begin
    repeat (8) @(negedge clock);
    reset_line_n = 1;
    t_boot();
    t_ext_reset();
    t_power_cycle();
    t_modes();
    t_wdog();
    t_uv();
    t_overtemp();
    give_verdict();
  end
endmodule
`default_nettype wire
